// file: common/aux_power_params.svh
// constants for the auxiliary power enable sampler
`ifndef AUX_POWER_PARAMS_SVH
`define AUX_POWER_PARAMS_SVH

// sample points, in core clocks after fundamental reset release
`define STICKY_SAMPLE_CYC  9'd8
`define ENABLE_SAMPLE_CYC  9'd256
`define SAMPLE_CNT_W       9

// register offsets (byte addresses)
`define CTRL_OFFSET        4'h0
`define STATUS_OFFSET      4'h4
`define STICKY_OFFSET      4'h8

// control register fields
`define CTRL_AUX_EN_BIT    0
`define CTRL_PME_EN_BIT    1
`define CTRL_STANDBY_BIT   2

// status register fields
`define STAT_DETECTED_BIT  0
`define STAT_L2_EN_BIT     1
`define STAT_DONE_BIT      2
`define STAT_STICKY_INIT   3

`define STICKY_W           16
`define STICKY_RESET       16'h0000

`endif

// file: common/aux_power_pkg.sv
// types for the auxiliary power enable sampler
`default_nettype none
package aux_power_pkg;
  typedef enum logic [1:0] {
    ST_HELD,
    ST_WAIT_STICKY,
    ST_WAIT_ENABLE,
    ST_DONE
  } sample_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [3:0]  adr;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;
endpackage
`default_nettype wire

// file: src/aux_power_enable_sampler.sv
// auxiliary power enable sampler with wishbone register slave
//
// Function
// - sample disable input 8 clocks after reset release; low initializes sticky bits
// - high at the 8-clock sample keeps sticky bits unchanged
// - sample again at 256 clocks; high sets the aux power enable bit
// - low at the 256-clock sample clears the aux power enable bit
// - aux power detected reads set only while the enable bit is one
// - detected status follows enable bit alone, no supply sensing
// - software may set enable bit by write only when pme enable is set
// - core clock is gated off during active standby
// - sticky fields survive all resets except the initialization path
// - L2 mode enabled only when detected and pme enable both set
`include "aux_power_params.svh"
`default_nettype none
module aux_power_enable_sampler (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  fundamental_reset_n_i,
  input  wire logic                  aux_power_disable_n_i,
  input  wire aux_power_pkg::wb_req_t wb_req_i,
  output var  aux_power_pkg::wb_rsp_t wb_rsp_o,
  output logic                       aux_power_detected_o,
  output logic                       l2_mode_enabled_o,
  output logic                       core_clk_gate_o
);
  import aux_power_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] perst_sync_q;
  logic [1:0] disable_sync_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      perst_sync_q   <= 2'h0;
      disable_sync_q <= 2'h0;
    end else begin
      perst_sync_q   <= {perst_sync_q[0], fundamental_reset_n_i};
      disable_sync_q <= {disable_sync_q[0], aux_power_disable_n_i};
    end
  end

  logic perst_n_s;
  logic disable_n_s;
  assign perst_n_s   = perst_sync_q[1];
  assign disable_n_s = disable_sync_q[1];

  // ----------------------------------------------------------------
  // sample sequencer
  // ----------------------------------------------------------------
  sample_state_t                 state_q;
  logic [`SAMPLE_CNT_W-1:0]      cnt_q;
  logic                          sticky_take;
  logic                          enable_take;

  // cycle count starts at 1 in the first cycle after release
  assign sticky_take = (state_q == ST_WAIT_STICKY) &&
                       (cnt_q == `STICKY_SAMPLE_CYC);
  assign enable_take = (state_q == ST_WAIT_ENABLE) &&
                       (cnt_q == `ENABLE_SAMPLE_CYC);

  always_ff @(posedge clk_i) begin
    if (rst_i || !perst_n_s) begin
      state_q <= ST_HELD;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        ST_HELD: begin
          state_q <= ST_WAIT_STICKY;
          cnt_q   <= `SAMPLE_CNT_W'(1);
        end
        ST_WAIT_STICKY: begin
          cnt_q <= cnt_q + `SAMPLE_CNT_W'(1);
          if (sticky_take) begin
            state_q <= ST_WAIT_ENABLE;
          end
        end
        ST_WAIT_ENABLE: begin
          cnt_q <= cnt_q + `SAMPLE_CNT_W'(1);
          if (enable_take) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          cnt_q <= cnt_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register write decode
  // ----------------------------------------------------------------
  logic wr_ctrl;
  logic wr_sticky;
  logic bus_hit;
  logic ack_q;

  assign bus_hit   = wb_req_i.cyc && wb_req_i.stb && !ack_q;
  assign wr_ctrl   = bus_hit && wb_req_i.we && wb_req_i.sel[0] &&
                     (wb_req_i.adr == `CTRL_OFFSET);
  assign wr_sticky = bus_hit && wb_req_i.we &&
                     (wb_req_i.adr == `STICKY_OFFSET);

  // ----------------------------------------------------------------
  // sticky bits: the low sample clears them, a bus write loads them, no reset does
  // ----------------------------------------------------------------
  logic [`STICKY_W-1:0] sticky_q;
  logic                 sticky_init_q;

  always_ff @(posedge clk_i) begin
    if (sticky_take && !disable_n_s) begin
      sticky_q <= `STICKY_RESET;
    end else if (wr_sticky) begin
      if (wb_req_i.sel[0]) sticky_q[7:0]  <= wb_req_i.dat[7:0];
      if (wb_req_i.sel[1]) sticky_q[15:8] <= wb_req_i.dat[15:8];
    end
    // a high sample leaves sticky_q untouched
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sticky_init_q <= 1'b0;
    end else if (sticky_take) begin
      sticky_init_q <= !disable_n_s;
    end
  end

  // ----------------------------------------------------------------
  // control bits
  // ----------------------------------------------------------------
  logic aux_en_q;
  logic pme_en_q;
  logic standby_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_en_q <= 1'b0;
    end else if (enable_take) begin
      aux_en_q <= disable_n_s;
    end else if (wr_ctrl) begin
      if (!wb_req_i.dat[`CTRL_AUX_EN_BIT]) begin
        aux_en_q <= 1'b0;
      end else if (pme_en_q) begin
        aux_en_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pme_en_q  <= 1'b0;
      standby_q <= 1'b0;
    end else if (wr_ctrl) begin
      pme_en_q  <= wb_req_i.dat[`CTRL_PME_EN_BIT];
      standby_q <= wb_req_i.dat[`CTRL_STANDBY_BIT];
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_power_detected_o <= 1'b0;
      l2_mode_enabled_o    <= 1'b0;
      core_clk_gate_o      <= 1'b0;
    end else begin
      aux_power_detected_o <= aux_en_q;
      l2_mode_enabled_o    <= aux_en_q && pme_en_q;
      // active standby: l2 enabled and standby control bit set
      core_clk_gate_o      <= standby_q && aux_en_q && pme_en_q;
    end
  end

  // ----------------------------------------------------------------
  // wishbone read and ack
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q         <= 1'b0;
      wb_rsp_o      <= '0;
    end else begin
      ack_q         <= bus_hit;
      wb_rsp_o.ack  <= bus_hit;
      wb_rsp_o.dat  <= 32'h0000_0000;
      if (bus_hit && !wb_req_i.we) begin
        unique case (wb_req_i.adr)
          `CTRL_OFFSET: begin
            wb_rsp_o.dat[`CTRL_AUX_EN_BIT]  <= aux_en_q;
            wb_rsp_o.dat[`CTRL_PME_EN_BIT]  <= pme_en_q;
            wb_rsp_o.dat[`CTRL_STANDBY_BIT] <= standby_q;
          end
          `STATUS_OFFSET: begin
            wb_rsp_o.dat[`STAT_DETECTED_BIT] <= aux_en_q;
            wb_rsp_o.dat[`STAT_L2_EN_BIT]    <= aux_en_q && pme_en_q;
            wb_rsp_o.dat[`STAT_DONE_BIT]     <= (state_q == ST_DONE);
            wb_rsp_o.dat[`STAT_STICKY_INIT]  <= sticky_init_q;
          end
          `STICKY_OFFSET: begin
            wb_rsp_o.dat[`STICKY_W-1:0] <= sticky_q;
          end
          default: begin
            wb_rsp_o.dat <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_sticky_clear;
    @(posedge clk_i) disable iff (rst_i)
      (sticky_take && !disable_n_s) |=> (sticky_q == `STICKY_RESET);
  endproperty
  a_sticky_clear: assert property (p_sticky_clear)
    else $error("sticky bits not initialized on low sample");

  property p_sticky_keep;
    @(posedge clk_i) disable iff (rst_i)
      (sticky_take && disable_n_s && !wr_sticky) |=> $stable(sticky_q);
  endproperty
  a_sticky_keep: assert property (p_sticky_keep)
    else $error("sticky bits changed on high sample");

  property p_enable_set;
    @(posedge clk_i) disable iff (rst_i)
      (enable_take && disable_n_s) |=> aux_en_q ##2 aux_power_detected_o;
  endproperty
  a_enable_set: assert property (p_enable_set)
    else $error("enable bit not set on high sample");

  property p_enable_clear;
    @(posedge clk_i) disable iff (rst_i)
      (enable_take && !disable_n_s) |=> !aux_en_q;
  endproperty
  a_enable_clear: assert property (p_enable_clear)
    else $error("enable bit not cleared on low sample");

  // the edge after a reset still sees the pre-reset enable bit in $past
  property p_detected;
    @(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) |-> aux_power_detected_o == $past(aux_en_q);
  endproperty
  a_detected: assert property (p_detected)
    else $error("detected status does not follow enable bit");

  property p_sw_set;
    @(posedge clk_i) disable iff (rst_i)
      (wr_ctrl && !enable_take && !aux_en_q && !pme_en_q) |=> !aux_en_q;
  endproperty
  a_sw_set: assert property (p_sw_set)
    else $error("enable set without pme enable");

  property p_l2;
    @(posedge clk_i) disable iff (rst_i)
      l2_mode_enabled_o |-> $past(aux_en_q) && $past(pme_en_q);
  endproperty
  a_l2: assert property (p_l2)
    else $error("l2 enabled without both bits");

  property p_sample_point;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == ST_HELD) ##1 (state_q == ST_WAIT_STICKY) [*8]
        |=> (state_q == ST_WAIT_ENABLE) || (state_q == ST_HELD);
  endproperty
  a_sample_point: assert property (p_sample_point)
    else $error("first sample not at cycle 8");

  property p_done_hold;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == ST_DONE) && perst_n_s |=> (state_q == ST_DONE);
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("sequencer left done state");

  c_init: cover property (@(posedge clk_i) sticky_take && !disable_n_s);
  c_keep: cover property (@(posedge clk_i) sticky_take && disable_n_s);
  c_en:   cover property (@(posedge clk_i) enable_take && disable_n_s);
  c_sw:   cover property (@(posedge clk_i) wr_ctrl && pme_en_q);
endmodule
`default_nettype wire

// file: dv/por_model.sv
// model of the external power-on reset circuitry
`default_nettype none
module por_model (
  input  wire logic clk_i,
  output logic      fundamental_reset_n_o,
  output logic      aux_power_disable_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    fundamental_reset_n_o = 1'b0;
    aux_power_disable_n_o = 1'b0;
  end

  // mode 0: low at first sample then high, 1: held high, 2: tied low
  task automatic power_up(input int mode);
    fundamental_reset_n_o <= 1'b0;
    aux_power_disable_n_o <= (mode == 1);
    repeat (4) @(posedge clk_i);
    fundamental_reset_n_o <= 1'b1;
    repeat (100) @(posedge clk_i);
    if (mode == 0) aux_power_disable_n_o <= 1'b1;
    repeat (250) @(posedge clk_i);
  endtask

  task automatic follow(input logic lvl);
    aux_power_disable_n_o <= lvl;
  endtask
endmodule
`default_nettype wire

// file: dv/test_aux_power_enable_sampler.sv
// self-checking bench for the auxiliary power enable sampler
`include "aux_power_params.svh"
`default_nettype none
module test_aux_power_enable_sampler;
  timeunit 1ns;
  timeprecision 1ps;
  import aux_power_pkg::*;

  logic        clk_i, rst_i, rst_n, dis_n, det, l2, gate;
  wb_req_t     req;
  wb_rsp_t     rsp;
  logic [31:0] exp_q[$], msk_q[$];
  int          n_mismatch, checks_done;
  logic [15:0] keep;

  aux_power_enable_sampler dut (.clk_i(clk_i), .rst_i(rst_i),
    .fundamental_reset_n_i(rst_n), .aux_power_disable_n_i(dis_n),
    .wb_req_i(req), .wb_rsp_o(rsp), .aux_power_detected_o(det),
    .l2_mode_enabled_o(l2), .core_clk_gate_o(gate));
  por_model por (.clk_i(clk_i), .fundamental_reset_n_o(rst_n),
    .aux_power_disable_n_o(dis_n));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic cmp32(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, exp);
    cmp32({31'h0, got}, {31'h0, exp});
  endtask

  task automatic wb(input logic we, input logic [3:0] adr,
                    input logic [31:0] d);
    req <= '{1'b1, 1'b1, we, 4'hF, adr, d};
    // only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (rsp.ack !== 1'b1);
    req <= '0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [3:0] adr, input logic [31:0] m, e);
    msk_q.push_back(m);
    exp_q.push_back(e);
    wb(1'b0, adr, 32'h0);
  endtask

  // read data is judged at the edge where ack is seen
  always @(posedge clk_i) begin
    if (rsp.ack === 1'b1 && req.we === 1'b0 && exp_q.size() > 0)
      cmp32(rsp.dat & msk_q.pop_front(), exp_q.pop_front());
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    #40000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    req = '0;
    rst_i = 1'b1;
    n_mismatch = 0;
    checks_done = 0;
    void'($urandom(19527));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    por.power_up(0);
    cmp1(det, 1'b1);
    cmp1(l2, 1'b0);
    rd(`STATUS_OFFSET, 32'hF, 32'hD);
    rd(`STICKY_OFFSET, 32'hFFFF, 32'h0);
    keep = 16'($urandom());
    wb(1'b1, `STICKY_OFFSET, {16'h0, keep});
    wb(1'b1, `CTRL_OFFSET, 32'h3);
    repeat (2) @(posedge clk_i);
    cmp1(l2, 1'b1);
    $display("test 1 done");
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    por.power_up(1);
    rd(`STICKY_OFFSET, 32'hFFFF, {16'h0, keep});
    cmp1(det, 1'b1);
    por.follow(1'b0);
    repeat (20) @(posedge clk_i);
    cmp1(det, 1'b1);
    $display("test 2 done");
    por.power_up(2);
    cmp1(det, 1'b0);
    rd(`STICKY_OFFSET, 32'hFFFF, 32'h0);
    wb(1'b1, `CTRL_OFFSET, 32'h1);
    repeat (3) @(posedge clk_i);
    cmp1(det, 1'b0);
    wb(1'b1, `CTRL_OFFSET, 32'h2);
    wb(1'b1, `CTRL_OFFSET, 32'h3);
    por.follow(1'b1);
    repeat (3) @(posedge clk_i);
    cmp1(det, 1'b1);
    cmp1(l2, 1'b1);
    wb(1'b1, `CTRL_OFFSET, 32'h7);
    repeat (3) @(posedge clk_i);
    cmp1(gate, 1'b1);
    rd(4'hC, 32'hFFFFFFFF, 32'h0);
    $display("test 3 done");
    wrap_up();
  end
endmodule
`default_nettype wire
